/* File: core/multichannel_temp_alarm_logic.sv */
/*
 * Digital core of a five channel temperature monitor: result encoding
 * and hold, alert and overtemperature logic, register file, and an
 * SMBus slave running on the bus clock.
 * Assumes a converter front end on clk that answers each convStart
 * with one convDone pulse, and an SMBus host driving the bus clock.
 */
`timescale 1ns/100ps
`default_nettype none
module multichannel_temp_alarm_logic
   import temp_alarm_pkg::*;
#(
   parameter int         FAULT_CYCLES   = FAULT_DETECT_CYC,
   parameter int         TIMEOUT_CYCLES = BUS_TIMEOUT_CYC,
   parameter logic [6:0] SLAVE_ADDR     = 7'h2a,  // arbitrary value
   parameter logic [7:0] MFR_ID         = 8'h5c,  // arbitrary value
   parameter logic [7:0] SHORT_CODE     = TEMP_SHORT
) (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               smbClk,
   input  wire logic               smbDataIn,
   output var  logic               smbDataOut,
   output var  logic               smbDataOe,
   output var  logic               alertNOe,
   output var  logic               overtempTripNOe,
   output var  logic               convStart,
   output var  logic [2:0]         convChan,
   input  wire logic               convDone,
   input  wire logic signed [11:0] convTemp,
   input  wire logic               diodeOpen,
   input  wire logic               diodeShort,
   output var  logic               srcEnable
);
   localparam int FCW = $clog2(FAULT_CYCLES + 1);
   localparam int TCW = $clog2(TIMEOUT_CYCLES + 1);

   typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_FAULT} seq_t;
   typedef enum logic [2:0] {LM_IDLE, LM_ADDR, LM_CMD, LM_WDATA, LM_TX} lmode_t;

   typedef struct packed {
      logic [3:0]      tog1;
      logic [3:0]      tog2;
      logic [3:0]      tog3;
      logic [7:0]      ptr;
      logic [7:0]      rdByte;
      logic [4:0][7:0] tempHi;
      logic [7:0]      ext1;
      logic [4:0]      held;
      logic [TCW-1:0]  holdCnt;
      logic [4:0][7:0] alim;
      logic [7:0]      olim1;
      logic [7:0]      olim4;
      logic [7:0]      cfg1;
      logic [7:0]      cfg2;
      logic [7:0]      cfg3;
      logic [7:0]      stat1;
      logic [7:0]      stat2;
      logic [7:0]      stat3;
      logic [1:0]      overtAct;
      logic            alertLatch;
      logic            refresh;
      seq_t            seq;
      logic [2:0]      chan;
      logic [2:0]      base;
      logic            isShort;
      logic [FCW-1:0]  faultCnt;
      logic            convStart;
      logic            alertOe;
      logic            overtOe;
   } core_t;

   typedef struct packed {
      lmode_t     mode;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic [7:0] wrData;
      logic [3:0] tog;
      logic       ara;
      logic       isRd;
      logic       lost;
      logic       drv;
      logic       startAck;
      logic       ap1;
      logic       ap2;
   } link_t;

   core_t s_r, s_nxt;
   link_t l_r, l_nxt;
   logic  startTog_r;
   logic  sdaOe_r;
   logic  sdaOut_r;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [7:0] tempPtr(input int c);
      case (c)
         0:       return PTR_LOCAL;
         1:       return PTR_REM1;
         2:       return PTR_REM2;
         3:       return PTR_REM3;
         default: return PTR_REM4;
      endcase
   endfunction

   function automatic logic [7:0] alimPtr(input int c);
      case (c)
         0:       return PTR_ALIM0;
         1:       return PTR_ALIM1;
         2:       return PTR_ALIM2;
         3:       return PTR_ALIM3;
         default: return PTR_ALIM4;
      endcase
   endfunction

   // status and mask bit of a channel, local channel apart
   function automatic int alertBit(input int c);
      return (c == 0) ? ALRT_BIT_LOCAL : ALRT_BIT_REM1 + c - 1;
   endfunction

   function automatic core_t coreReset();
      core_t r;
      r         = '0;
      r.ptr     = RST_ZERO;
      r.cfg1    = RST_ZERO;
      r.cfg2    = RST_ZERO;
      r.cfg3    = RST_ZERO;
      r.alim[0] = RST_ALIM0;
      r.alim[1] = RST_ALIM1;
      r.alim[2] = RST_ALIM2;
      r.alim[3] = RST_ALIM3;
      r.alim[4] = RST_ALIM4;
      r.olim1   = RST_OLIM1;
      r.olim4   = RST_OLIM4;
      return r;
   endfunction

   // byte seen by the host at the current pointer
   function automatic logic [7:0] readMux(input core_t c);
      logic [7:0] r;
      r = RST_ZERO;
      for (int i = 0; i < 5; i++) begin
         if (c.ptr == tempPtr(i)) r = c.tempHi[i];
         if (c.ptr == alimPtr(i)) r = c.alim[i];
      end
      if (c.ptr == PTR_EXT1) r = c.ext1;
      else if (c.ptr == PTR_MFR) r = MFR_ID;
      else if (c.ptr == PTR_CFG1) r = c.cfg1;
      else if (c.ptr == PTR_CFG2) r = c.cfg2;
      else if (c.ptr == PTR_CFG3) r = c.cfg3;
      else if (c.ptr == PTR_STAT1) r = c.stat1;
      else if (c.ptr == PTR_STAT2) r = c.stat2;
      else if (c.ptr == PTR_STAT3) r = c.stat3;
      else if (c.ptr == PTR_OLIM1) r = c.olim1;
      else if (c.ptr == PTR_OLIM4) r = c.olim4;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // core domain: crossings, sequencer, alarms, register file

   always_comb begin
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] lim;
      logic [3:0] ev;
      logic       fault;
      logic       store;
      logic       softRst;
      int         c;
      int         ot;
      hi      = TEMP_MIN;
      lo      = TEMP_MIN;
      lim     = TEMP_MIN;
      fault   = 1'b0;
      store   = 1'b0;
      softRst = 1'b0;
      c       = int'(s_r.chan);
      ot      = (c == 4) ? OT_BIT_CH4 : OT_BIT_CH1;
      ev      = s_r.tog2 ^ s_r.tog3;
      s_nxt   = s_r;
      s_nxt.tog1      = l_r.tog;
      s_nxt.tog2      = s_r.tog1;
      s_nxt.tog3      = s_r.tog2;
      s_nxt.convStart = 1'b0;
      s_nxt.refresh   = 1'b0;

      // pointer arrives from the link
      if (ev[TOG_PTR]) begin
         s_nxt.ptr     = l_r.ptr;
         s_nxt.refresh = 1'b1;
      end
      // side effects of a completed read
      if (ev[TOG_RD]) begin
         for (int i = 0; i < 5; i++)
            if (s_r.ptr == tempPtr(i)) s_nxt.held[i] = 1'b0;
         if (s_r.ptr == PTR_STAT1) begin
            s_nxt.stat1      = '0;
            s_nxt.alertLatch = 1'b0;
         end
         if (s_r.ptr == PTR_STAT2) s_nxt.stat2 = '0;
         s_nxt.refresh = 1'b1;
      end
      if (ev[TOG_ARA]) s_nxt.alertLatch = 1'b0;
      if (s_r.refresh) s_nxt.rdByte = readMux(s_r);

      // held results go free after the bus timeout
      if (s_r.held != '0 && !s_r.cfg1[CFG1_NOTMO]) begin
         if (s_r.holdCnt == TCW'(TIMEOUT_CYCLES - 1)) begin
            s_nxt.held    = '0;
            s_nxt.holdCnt = '0;
         end else begin
            s_nxt.holdCnt = s_r.holdCnt + 1'b1;
         end
      end

      // result encoding, whole degrees and eighths
      if (convTemp[11]) begin
         hi = TEMP_MIN;
      end else if (convTemp[10]) begin
         hi = TEMP_MAX;
      end else begin
         hi = {1'b0, convTemp[9:3]};
         lo = {convTemp[2:0], 5'h00};
      end

      // conversion sequencer, never held back by alerts
      case (s_r.seq)
         SQ_IDLE: begin
            if (!s_r.cfg1[CFG1_STANDBY]) begin
               s_nxt.convStart = 1'b1;
               s_nxt.seq       = SQ_WAIT;
            end
         end
         SQ_WAIT: begin
            if (convDone) begin
               if (diodeOpen || diodeShort) begin
                  s_nxt.isShort  = diodeShort && !diodeOpen;
                  s_nxt.faultCnt = '0;
                  s_nxt.seq      = SQ_FAULT;
               end else begin
                  store = 1'b1;
               end
            end
         end
         SQ_FAULT: begin
            if (s_r.faultCnt == FCW'(FAULT_CYCLES - 1)) begin
               store = 1'b1;
               fault = 1'b1;
            end else begin
               s_nxt.faultCnt = s_r.faultCnt + 1'b1;
            end
         end
         default: s_nxt.seq = SQ_IDLE;
      endcase

      // store the result and update the alarms
      if (store) begin
         if (fault) begin
            hi = s_r.isShort ? SHORT_CODE : TEMP_OPEN;
            lo = TEMP_MIN;
         end
         if (!s_r.held[c]) begin
            s_nxt.tempHi[c] = hi;
            if (c == 1) s_nxt.ext1 = lo;
            s_nxt.held[c]   = 1'b1;
            s_nxt.holdCnt   = '0;
         end
         if (c != 0) s_nxt.stat3[c-1] = fault;
         if (!fault) begin
            if (hi > s_r.alim[c]) begin
               s_nxt.stat1[alertBit(c)] = 1'b1;
               if (!s_r.cfg2[alertBit(c)]) s_nxt.alertLatch = 1'b1;
            end
            if (c == 1 || c == 4) begin
               lim = (c == 4) ? s_r.olim4 : s_r.olim1;
               if (hi > lim) begin
                  s_nxt.overtAct[ot] = 1'b1;
                  s_nxt.stat2[ot]    = 1'b1;
               end else if ({1'b0, hi} + OT_HYST < {1'b0, lim}) begin
                  s_nxt.overtAct[ot] = 1'b0;
               end
            end
         end
         // next channel, channel 1 interleaved when asked
         if (s_r.cfg1[CFG1_CH1FAST] && s_r.chan != 3'd1) begin
            s_nxt.base = s_r.chan;
            s_nxt.chan = 3'd1;
         end else if (s_r.cfg1[CFG1_CH1FAST]) begin
            s_nxt.chan = (s_r.base == 3'd4) ? 3'd0 :
                         (s_r.base == 3'd0) ? 3'd2 : s_r.base + 3'd1;
         end else begin
            s_nxt.chan = (s_r.chan == 3'd4) ? 3'd0 : s_r.chan + 3'd1;
         end
         s_nxt.seq = SQ_IDLE;
      end

      // host writes at the current pointer
      if (ev[TOG_WR]) begin
         for (int i = 0; i < 5; i++)
            if (s_r.ptr == alimPtr(i)) s_nxt.alim[i] = l_r.wrData;
         if (s_r.ptr == PTR_OLIM1) s_nxt.olim1 = l_r.wrData;
         else if (s_r.ptr == PTR_OLIM4) s_nxt.olim4 = l_r.wrData;
         else if (s_r.ptr == PTR_CFG1) begin
            s_nxt.cfg1 = l_r.wrData & CFG1_WMASK;
            softRst    = l_r.wrData[CFG1_SOFTRST];
         end
         else if (s_r.ptr == PTR_CFG2) s_nxt.cfg2 = l_r.wrData & CFG2_WMASK;
         else if (s_r.ptr == PTR_CFG3) s_nxt.cfg3 = l_r.wrData & CFG3_WMASK;
         s_nxt.refresh = 1'b1;
      end

      // open-drain enables
      s_nxt.alertOe = s_r.alertLatch;
      s_nxt.overtOe =
         (s_r.overtAct[OT_BIT_CH1] && !(s_r.cfg3[OTM_CH1_A] || s_r.cfg3[OTM_CH1_B])) ||
         (s_r.overtAct[OT_BIT_CH4] && !(s_r.cfg3[OTM_CH4_A] || s_r.cfg3[OTM_CH4_B]));

      // soft reset keeps the crossing history intact
      if (softRst) begin
         s_nxt      = coreReset();
         s_nxt.tog1 = l_r.tog;
         s_nxt.tog2 = s_r.tog1;
         s_nxt.tog3 = s_r.tog2;
      end
      if (!rst_b) s_nxt = coreReset();
   end

   // core state register
   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // link domain: start detect, byte engine, data drive

   // start condition, data falling while the bus clock is high
   always_ff @(negedge smbDataIn or negedge rst_b) begin
      if (!rst_b) startTog_r <= 1'b0;
      else if (smbClk) startTog_r <= ~startTog_r;
   end

   always_comb begin
      logic [7:0] tx;
      logic       lostNow;
      logic       araHit;
      tx      = s_r.rdByte;
      lostNow = 1'b0;
      araHit  = 1'b0;
      l_nxt   = l_r;
      l_nxt.ap1 = s_r.alertOe;
      l_nxt.ap2 = l_r.ap1;
      if (startTog_r != l_r.startAck) begin
         // this edge already carries the first address bit
         l_nxt.startAck = startTog_r;
         l_nxt.mode     = LM_ADDR;
         l_nxt.shift    = {7'h00, smbDataIn};
         l_nxt.bitCnt   = 4'd1;
         l_nxt.drv      = 1'b0;
         l_nxt.lost     = 1'b0;
      end else if (l_r.mode != LM_IDLE) begin
         l_nxt.bitCnt = (l_r.bitCnt == 4'd8) ? 4'd0 : l_r.bitCnt + 4'd1;
         if (l_r.bitCnt != 4'd8) begin
            if (l_r.mode == LM_TX) begin
               lostNow     = l_r.lost || (!l_r.drv && !smbDataIn);
               l_nxt.lost  = lostNow;
               l_nxt.shift = {l_r.shift[6:0], 1'b0};
               l_nxt.drv   = (l_r.bitCnt != 4'd7) && !lostNow && !l_r.shift[6];
            end else begin
               l_nxt.shift = {l_r.shift[6:0], smbDataIn};
               if (l_r.bitCnt == 4'd7) begin
                  araHit     = (l_r.shift[6:0] == ARA_ADDR) && smbDataIn && l_r.ap2;
                  l_nxt.ara  = araHit;
                  l_nxt.isRd = smbDataIn;
                  l_nxt.drv  = (l_r.mode != LM_ADDR) || araHit ||
                               (l_r.shift[6:0] == SLAVE_ADDR);
               end
            end
         end else begin
            l_nxt.drv = 1'b0;
            case (l_r.mode)
               LM_ADDR: begin
                  if (!l_r.drv) begin
                     l_nxt.mode = LM_IDLE;
                  end else if (l_r.isRd) begin
                     tx          = l_r.ara ? {SLAVE_ADDR, 1'b0} : s_r.rdByte;
                     l_nxt.shift = tx;
                     l_nxt.drv   = !tx[7];
                     l_nxt.lost  = 1'b0;
                     l_nxt.mode  = LM_TX;
                  end else begin
                     l_nxt.mode = LM_CMD;
                  end
               end
               LM_CMD: begin
                  l_nxt.ptr          = l_r.shift;
                  l_nxt.tog[TOG_PTR] = ~l_r.tog[TOG_PTR];
                  l_nxt.mode         = LM_WDATA;
               end
               LM_WDATA: begin
                  l_nxt.wrData      = l_r.shift;
                  l_nxt.tog[TOG_WR] = ~l_r.tog[TOG_WR];
                  l_nxt.mode        = LM_IDLE;
               end
               LM_TX: begin
                  if (!l_r.ara) l_nxt.tog[TOG_RD] = ~l_r.tog[TOG_RD];
                  else if (!l_r.lost) l_nxt.tog[TOG_ARA] = ~l_r.tog[TOG_ARA];
                  l_nxt.mode = LM_IDLE;
               end
               default: l_nxt.mode = LM_IDLE;
            endcase
         end
      end
   end

   // link state register, bus clock may stop between frames
   always_ff @(posedge smbClk or negedge rst_b) begin
      if (!rst_b) l_r <= '0;
      else l_r <= l_nxt;
   end

   // data line changes only while the bus clock is low
   always_ff @(negedge smbClk or negedge rst_b) begin
      if (!rst_b) begin
         sdaOe_r  <= 1'b0;
         sdaOut_r <= 1'b0;
      end else begin
         sdaOe_r  <= l_r.drv;
         sdaOut_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign smbDataOut      = sdaOut_r;
   assign smbDataOe       = sdaOe_r;
   assign alertNOe        = s_r.alertOe;
   assign overtempTripNOe = s_r.overtOe;
   assign convStart       = s_r.convStart;
   assign convChan        = s_r.chan;
   assign srcEnable       = s_r.cfg1[CFG1_SRC];
endmodule // multichannel_temp_alarm_logic
`default_nettype wire

/* File: core/temp_alarm_pkg.sv */
/*
 * Constants shared by the temperature alarm core: register pointers,
 * reset values, field positions and timing counts.
 * Assumes a 50 MHz core clock and an SMBus host on the two-wire link.
 */
package temp_alarm_pkg;
   // register pointers
   localparam logic [7:0] PTR_LOCAL = 8'h07;
   localparam logic [7:0] PTR_REM1  = 8'h01;
   localparam logic [7:0] PTR_REM2  = 8'h02;
   localparam logic [7:0] PTR_REM3  = 8'h03;
   localparam logic [7:0] PTR_REM4  = 8'h04;
   localparam logic [7:0] PTR_EXT1  = 8'h09;
   localparam logic [7:0] PTR_MFR   = 8'h0a;
   localparam logic [7:0] PTR_CFG1  = 8'h41;
   localparam logic [7:0] PTR_CFG2  = 8'h42;
   localparam logic [7:0] PTR_CFG3  = 8'h43;
   localparam logic [7:0] PTR_STAT1 = 8'h44;
   localparam logic [7:0] PTR_STAT2 = 8'h45;
   localparam logic [7:0] PTR_STAT3 = 8'h46;
   localparam logic [7:0] PTR_ALIM0 = 8'h17;
   localparam logic [7:0] PTR_ALIM1 = 8'h11;
   localparam logic [7:0] PTR_ALIM2 = 8'h12;
   localparam logic [7:0] PTR_ALIM3 = 8'h13;
   localparam logic [7:0] PTR_ALIM4 = 8'h14;
   localparam logic [7:0] PTR_OLIM1 = 8'h21;
   localparam logic [7:0] PTR_OLIM4 = 8'h24;
   // reset values
   localparam logic [7:0] RST_ZERO  = 8'h00;
   localparam logic [7:0] RST_ALIM0 = 8'h5a;
   localparam logic [7:0] RST_ALIM1 = 8'h6e;
   localparam logic [7:0] RST_ALIM2 = 8'h7f;
   localparam logic [7:0] RST_ALIM3 = 8'h7f;
   localparam logic [7:0] RST_ALIM4 = 8'h64;
   localparam logic [7:0] RST_OLIM1 = 8'h6e;
   localparam logic [7:0] RST_OLIM4 = 8'h7f;
   // field positions and write masks
   localparam int CFG1_STANDBY = 7;
   localparam int CFG1_SOFTRST = 6;
   localparam int CFG1_NOTMO   = 5;
   localparam int CFG1_CH1FAST = 4;
   localparam int CFG1_SRC     = 3;
   localparam logic [7:0] CFG1_WMASK = 8'hb8;
   localparam logic [7:0] CFG2_WMASK = 8'h7c;
   localparam logic [7:0] CFG3_WMASK = 8'h39;
   localparam int ALRT_BIT_LOCAL = 6;
   localparam int ALRT_BIT_REM1  = 2;
   localparam int OTM_CH1_A = 0;
   localparam int OTM_CH1_B = 3;
   localparam int OTM_CH4_A = 4;
   localparam int OTM_CH4_B = 5;
   localparam int OT_BIT_CH1 = 0;
   localparam int OT_BIT_CH4 = 1;
   // result codes
   localparam logic [7:0] TEMP_MAX   = 8'h7f;
   localparam logic [7:0] TEMP_MIN   = 8'h00;
   localparam logic [7:0] TEMP_OPEN  = 8'hff;
   localparam logic [7:0] TEMP_SHORT = 8'hee;
   localparam logic [8:0] OT_HYST    = 9'h004;
   // link constants and toggle lanes
   localparam logic [6:0] ARA_ADDR = 7'h0c;
   localparam int TOG_PTR = 0;
   localparam int TOG_WR  = 1;
   localparam int TOG_RD  = 2;
   localparam int TOG_ARA = 3;
   // timing
   localparam int CLK_MHZ          = 50;
   localparam int FAULT_DETECT_US  = 4000;
   localparam int BUS_TIMEOUT_US   = 37000;
   localparam int FAULT_DETECT_CYC = FAULT_DETECT_US * CLK_MHZ;
   localparam int BUS_TIMEOUT_CYC  = BUS_TIMEOUT_US * CLK_MHZ;
endpackage

/* File: dv/multichannel_temp_alarm_logic_tb.sv */
/* bench of the alarm core: host model on the bus, converter model
   on the front end; assumes 50 MHz core clock, 48 ns bus clock */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module multichannel_temp_alarm_logic_tb
   import temp_alarm_pkg::*;
;
   localparam logic [6:0] SA = 7'h2a;
   logic               clk, rst_b, hostOe, dataOe, dataOut, alertNOe, otNOe, scl;
   logic               convStart, convDone, diodeOpen, diodeShort, srcEnable;
   logic [2:0]         convChan;
   logic signed [11:0] convTemp;
   logic signed [11:0] tempOf [5] = '{12'sd1600, 12'sd805, -12'sd40, 12'sd0, 12'sd0};
   logic [8:0]         r;
   int                 n_fail, compares, cyc, starts;
   wire logic          sda = ~(hostOe | dataOe);
   multichannel_temp_alarm_logic #(.FAULT_CYCLES(20), .TIMEOUT_CYCLES(64), .SLAVE_ADDR(SA))
   multichannel_temp_alarm_logic_inst (.clk(clk), .rst_b(rst_b), .smbClk(scl),
      .smbDataIn(sda), .smbDataOut(dataOut), .smbDataOe(dataOe), .alertNOe(alertNOe),
      .overtempTripNOe(otNOe), .convStart(convStart), .convChan(convChan),
      .convDone(convDone), .convTemp(convTemp), .diodeOpen(diodeOpen),
      .diodeShort(diodeShort), .srcEnable(srcEnable));
   smb_host smb_host_inst (.scl(scl), .oe(hostOe), .sda(sda));
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // converter: answers each start eight cycles later; 3 open, 4 short
   always @(posedge clk) begin
      #1 convDone = 1'b0;
      cyc++;
      if (cyc > 30000) begin
         n_fail++;
         summarize();
      end
      if (convStart) begin
         starts++;
         repeat (8) @(posedge clk);
         #1 convDone = 1'b1;
         convTemp = tempOf[convChan];
         diodeOpen = (convChan == 3'h3);
         diodeShort = (convChan == 3'h4);
      end
   end
   // write byte protocol
   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      smb_host_inst.start();
      smb_host_inst.xfer({SA, 2'b01}, r);
      smb_host_inst.xfer({p, 1'b1}, r);
      smb_host_inst.xfer({v, 1'b1}, r);
      smb_host_inst.stop();
   endtask
   // receive byte at last pointer, masked compare
   task automatic rx(input logic [7:0] e, input logic [7:0] m = 8'hff);
      smb_host_inst.start();
      smb_host_inst.xfer({SA, 2'b11}, r);
      smb_host_inst.xfer(9'h1ff, r);
      smb_host_inst.stop();
      `CHK(r[8:1] & m, e)
   endtask
   // read byte protocol
   task automatic rc(input logic [7:0] p, input logic [7:0] e, input logic [7:0] m = 8'hff);
      smb_host_inst.start();
      smb_host_inst.xfer({SA, 2'b01}, r);
      smb_host_inst.xfer({p, 1'b1}, r);
      rx(e, m);
   endtask
   // alert response: address ack checked, then one byte
   task automatic ara(input logic [8:0] tx);
      smb_host_inst.start();
      smb_host_inst.xfer({ARA_ADDR, 2'b11}, r);
      `CHK(r[0], 1'b0)
      smb_host_inst.xfer(tx, r);
      smb_host_inst.stop();
      repeat (10) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      rc(PTR_CFG1, 8'h00);
      rc(PTR_CFG2, 8'h00);
      rc(PTR_CFG3, 8'h00);
      rc(PTR_ALIM0, RST_ALIM0);
      rc(PTR_OLIM4, RST_OLIM4);
      wr(PTR_ALIM4, 8'h55);
      rc(PTR_ALIM4, 8'h55);
   endtask
   task automatic t_results();
      repeat (400) @(posedge clk);
      rc(PTR_LOCAL, TEMP_MAX);
      rc(PTR_REM1, 8'h64);
      rc(PTR_EXT1, 8'ha0, 8'he0);
      rc(PTR_REM2, TEMP_MIN);
      rc(PTR_REM3, TEMP_OPEN);
      rc(PTR_REM4, TEMP_SHORT);
      rc(PTR_STAT3, 8'h0c);
   endtask
   // alert: raise, clear by read, standby, response address, mask
   task automatic t_alert();
      `CHK(alertNOe, 1'b1)
      wr(PTR_CFG1, 8'h80);
      repeat (300) @(posedge clk);
      starts = 0;
      rc(PTR_STAT1, 8'h40);
      repeat (200) @(posedge clk);
      `CHK(alertNOe, 1'b0)
      `CHK(starts, 0)
      wr(PTR_CFG1, 8'h00);
      repeat (300) @(posedge clk);
      `CHK(alertNOe, 1'b1)
      `CHK(starts > 0, 1'b1)
      wr(PTR_CFG1, 8'h80);
      repeat (100) @(posedge clk);
      ara(9'h000);
      `CHK(alertNOe, 1'b1)
      ara(9'h1ff);
      `CHK(r[8:1], {SA, 1'b0})
      `CHK(alertNOe, 1'b0)
      wr(PTR_CFG2, 8'h40);
      wr(PTR_CFG1, 8'h00);
      repeat (300) @(posedge clk);
      `CHK(alertNOe, 1'b0)
      rc(PTR_STAT1, 8'h40);
   endtask
   // overtemp trip, hysteresis, status read and mask
   task automatic t_overtemp();
      wr(PTR_OLIM1, 8'h60);
      repeat (200) @(posedge clk);
      `CHK(otNOe, 1'b1)
      rc(PTR_STAT2, 8'h01);
      `CHK(otNOe, 1'b1)
      wr(PTR_OLIM1, 8'h66);
      repeat (200) @(posedge clk);
      `CHK(otNOe, 1'b1)
      wr(PTR_OLIM1, 8'h6a);
      repeat (200) @(posedge clk);
      `CHK(otNOe, 1'b0)
      wr(PTR_OLIM1, 8'h60);
      wr(PTR_CFG3, 8'hff);
      repeat (200) @(posedge clk);
      `CHK(otNOe, 1'b0)
      rc(PTR_CFG3, CFG3_WMASK);
   endtask
   // control bits, soft reset, pointer kept for receive byte
   task automatic t_config();
      wr(PTR_CFG1, 8'hbf);
      rc(PTR_CFG1, 8'hb8);
      `CHK(srcEnable, 1'b1)
      wr(PTR_CFG1, 8'h40);
      repeat (10) @(posedge clk);
      rc(PTR_CFG1, 8'h00);
      rc(PTR_CFG3, 8'h00);
      rc(PTR_OLIM1, RST_OLIM1);
      rx(RST_OLIM1);
      `CHK(srcEnable, 1'b0)
      // result held until read, timeout off, then freed by timeout
      wr(PTR_CFG1, 8'h20);
      repeat (200) @(posedge clk);
      tempOf[2] = 12'sd400;
      repeat (300) @(posedge clk);
      rc(PTR_REM2, TEMP_MIN);
      repeat (300) @(posedge clk);
      tempOf[2] = -12'sd40;
      wr(PTR_CFG1, 8'h00);
      repeat (300) @(posedge clk);
      rc(PTR_REM2, TEMP_MIN);
   endtask
   task automatic summarize();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // reset, then the scenarios in order
   initial begin
      rst_b = 1'b1;
      convDone = 1'b0;
      convTemp = 12'sd0;
      diodeOpen = 1'b0;
      diodeShort = 1'b0;
      #1 rst_b = 1'b0;  // a real falling edge for the link reset
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_results();
      t_alert();
      t_overtemp();
      t_config();
      summarize();
   end
endmodule // multichannel_temp_alarm_logic_tb
`default_nettype wire

/* File: dv/smb_host.sv */
/* host master model of the two-wire bus: makes the bus clock,
   pulls the data wire low; assumes a pulled-up wire resolved outside */
`timescale 1ns/100ps
`default_nettype none
module smb_host (
   output var  logic scl,
   output var  logic oe,
   input  wire logic sda
);
   // bus idle: clock stands high between frames, data released
   initial begin
      scl = 1'b1;
      oe  = 1'b0;
   end
   // start or repeated start: data falls while clock high
   task automatic start();
      oe = 1'b0;
      #12 scl = 1'b1;
      #12 oe = 1'b1;
      #12 scl = 1'b0;
   endtask
   // stop: data rises while clock high, then bus rests
   task automatic stop();
      oe = 1'b1;
      #12 scl = 1'b1;
      #12 oe = 1'b0;
      #48;
   endtask
   // nine clocks of 48 ns: eight bits msb first, then ack slot
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #12 oe = ~tx[i];
         #12 scl = 1'b1;
         #12 rx[i] = sda;
         #12 scl = 1'b0;
      end
   endtask
endmodule // smb_host
`default_nettype wire

/* File: dv/temp_alarm_monitor.sv */
/* port checks of the alarm core, bound to its top;
   assumes one core clock and its active-low reset */
`timescale 1ns/100ps
`default_nettype none
module temp_alarm_monitor #(
   parameter int FAULT_CYCLES = 20
) (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       smbClk,
   input wire logic       smbDataOut,
   input wire logic       smbDataOe,
   input wire logic       alertNOe,
   input wire logic       convStart,
   input wire logic [2:0] convChan,
   input wire logic       convDone,
   input wire logic       diodeOpen,
   input wire logic       diodeShort
);
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic busy_r;
   int   wait_r;
   logic oeLow_r;
   // data enable as it stood when the bus clock rose
   always_ff @(posedge smbClk or negedge rst_b) begin
      if (!rst_b) oeLow_r <= 1'b0;
      else oeLow_r <= smbDataOe;
   end
   // open conversion and remaining fault detection wait
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
         wait_r <= 0;
      end else begin
         busy_r <= convStart | (busy_r & ~convDone);
         wait_r <= (convDone & (diodeOpen | diodeShort)) ? FAULT_CYCLES - 1 :
                   (wait_r > 0) ? wait_r - 1 : 0;
      end
   end
   sequence pulseOnce;
      convStart ##1 !convStart;
   endsequence
   sequence doneLately;
      $past(convDone, 2) || $past(convDone, 3) || $past(convDone, 4);
   endsequence
   AST_SDA_LOW_ONLY: assert property (smbDataOe |-> !smbDataOut)
      else $error("data line driven high");
   AST_CONV_PULSE: assert property (convStart |-> pulseOnce)
      else $error("start longer than one cycle");
   AST_CHAN_RANGE: assert property (convStart |-> convChan <= 3'h4)
      else $error("channel out of range");
   AST_NO_RESTART: assert property (convStart |-> !busy_r)
      else $error("start while conversion open");
   AST_FAULT_WAIT: assert property (convStart |-> wait_r == 0)
      else $error("start during fault detection");
   AST_CHAN_HOLD: assert property (busy_r |-> $stable(convChan))
      else $error("channel moved in conversion");
   AST_ALERT_CAUSE: assert property ($rose(alertNOe) |-> doneLately)
      else $error("alert without conversion end");
   AST_OE_CLOCK_LOW: assert property (@(negedge smbClk) smbDataOe == oeLow_r)
      else $error("data changed with clock high");
endmodule // temp_alarm_monitor
bind multichannel_temp_alarm_logic temp_alarm_monitor #(.FAULT_CYCLES(FAULT_CYCLES))
   temp_alarm_monitor_inst (.clk(clk), .rst_b(rst_b), .smbClk(smbClk),
   .smbDataOut(smbDataOut), .smbDataOe(smbDataOe), .alertNOe(alertNOe),
   .convStart(convStart), .convChan(convChan), .convDone(convDone),
   .diodeOpen(diodeOpen), .diodeShort(diodeShort));
`default_nettype wire
